//--- sysopt_params.svh
/*
 * Constants of the system option and part identification register bank.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Notes on behaviour
// R01: First options register: only first write honoured
// R02: First options register readable at any time
// R03: Software must write it during initialisation
// R04: Bit 7 enables watchdog; timeout forces reset
// R05: Bit 6 selects short or long timeout
// R06: Bit 5 permits stop; else illegal-opcode reset
// R07: Bit 1 gives debug pin its debug function
// R08: Any reset restores debug pin function
// R09: Bit 0 gives reset pin reset function
// R10: Reset pin restored only by power-on/low-voltage
// R11: Reset pin enable turns on pull-up
// R12: Second register bit 7: write-once watchdog clock
// R13: Bit 2 routes serial peripheral pins
// R14: Bit 1 routes two-wire bus pins
// R15: Bit 0 feeds comparator into second timer capture
// R16: Twelve-bit part number over two registers
// R17: High identification bits 7:4 reserved
// R18: Routing bits of second register freely writable
`ifndef SYSOPT_PARAMS_SVH
`define SYSOPT_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SYSOPT_OFF_OPT_ONE 4'h0
`define SYSOPT_OFF_OPT_TWO 4'h4
`define SYSOPT_OFF_ID_HIGH 4'h8
`define SYSOPT_OFF_ID_LOW 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SYSOPT_B1_WDOG_EN 7
`define SYSOPT_B1_WDOG_LONG 6
`define SYSOPT_B1_STOP_PERMIT 5
`define SYSOPT_B1_DEBUG_PIN 1
`define SYSOPT_B1_RESET_PIN 0
`define SYSOPT_B2_WDOG_CLK 7
`define SYSOPT_B2_SPI_SEL 2
`define SYSOPT_B2_TWI_SEL 1
`define SYSOPT_B2_CMP_CAP 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SYSOPT_RST_OPT_ONE 8'he3
`define SYSOPT_RST_OPT_TWO 8'h00
// Part number, arbitrary neutral value
`define SYSOPT_PART_NUMBER 12'h5a1

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define SYSOPT_RESP_OKAY 2'b00
`define SYSOPT_RESP_SLVERR 2'b10

`endif

//--- sysopt_pkg.sv
/*
 * Types of the system option register bank.
 * Assumes the constants header is on the include path.
 */
package sysopt_pkg;
    `include "sysopt_params.svh"

    // Bus slave states, one-hot
    typedef enum logic [2:0] {
        SYSOPT_IDLE = 3'b001,
        SYSOPT_WRESP = 3'b010,
        SYSOPT_RDATA = 3'b100
    } sysopt_state_t;

    // Decoded option outputs
    typedef struct packed {
        logic watchdog_enable;
        logic watchdog_long_timeout;
        logic watchdog_clock_select;
        logic stop_permit;
        logic debug_pin_enable;
        logic reset_pin_enable;
        logic reset_pin_pullup;
        logic serial_periph_pin_select;
        logic two_wire_pin_select;
        logic comparator_to_capture;
    } sysopt_ctrl_t;

    // Whole module state
    typedef struct packed {
        sysopt_state_t wstate;
        sysopt_state_t rstate;
        logic aw_got;
        logic w_got;
        logic [3:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic one_locked;
        logic two_locked;
        logic [7:0] opt_one;
        logic [7:0] opt_two;
    } sysopt_state_struct_t;
endpackage : sysopt_pkg

//--- sysopt_regs.sv
/*
 * System option and part identification register bank on AXI4-Lite.
 * Assumes one 50 MHz clock; rst_n is the power-on/low-voltage reset,
 * other_reset_n a synchronous pulse for all other reset sources.
 */
`timescale 1ns/1ps
`include "sysopt_params.svh"

module sysopt_regs
    import sysopt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic other_reset_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_executed,
    output logic illegal_stop_reset,
    output sysopt_ctrl_t ctrl
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sysopt_state_struct_t st_reg; // Registered state
    sysopt_state_struct_t st_next; // Next state
    logic wr_fire; // Both write halves held
    logic [7:0] wbyte; // Low byte of write data
    // Typed copies of header constants, since a bare literal cannot be sliced
    localparam logic [7:0] RST_ONE = `SYSOPT_RST_OPT_ONE; // Reset value of first options byte
    localparam logic [11:0] PART_NUM = `SYSOPT_PART_NUMBER; // Part number, both halves

    assign wr_fire = st_reg.aw_got && st_reg.w_got;
    assign wbyte = st_reg.wdata[7:0];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // Write address and data may arrive in either order
        if (st_reg.wstate == SYSOPT_IDLE) begin
            if (s_axi_awvalid && !st_reg.aw_got) begin
                st_next.aw_got = 1'b1;
                st_next.waddr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st_reg.w_got) begin
                st_next.w_got = 1'b1;
                st_next.wdata = s_axi_wdata;
                st_next.wstrb = s_axi_wstrb;
            end
        end
        case (st_reg.wstate)
            SYSOPT_IDLE: begin
                if (wr_fire) begin
                    st_next.bresp = `SYSOPT_RESP_OKAY;
                    case (st_reg.waddr)
                        `SYSOPT_OFF_OPT_ONE: begin
                            // Lock is used up by the first write, even with no byte lane
                            if (!st_reg.one_locked) begin // [R01]
                                st_next.one_locked = 1'b1; // [R01]
                                if (st_reg.wstrb[0]) begin
                                    st_next.opt_one = wbyte; // [R04] [R05] [R06] [R07] [R09]
                                end
                            end
                        end
                        `SYSOPT_OFF_OPT_TWO: begin
                            if (st_reg.wstrb[0]) begin
                                // Routing bits always writable
                                st_next.opt_two[`SYSOPT_B2_SPI_SEL] = wbyte[`SYSOPT_B2_SPI_SEL]; // [R13] [R18]
                                st_next.opt_two[`SYSOPT_B2_TWI_SEL] = wbyte[`SYSOPT_B2_TWI_SEL]; // [R14] [R18]
                                st_next.opt_two[`SYSOPT_B2_CMP_CAP] = wbyte[`SYSOPT_B2_CMP_CAP]; // [R15] [R18]
                            end
                            // Clock select only on the first write
                            if (!st_reg.two_locked) begin
                                st_next.two_locked = 1'b1; // [R12]
                                if (st_reg.wstrb[0]) begin
                                    st_next.opt_two[`SYSOPT_B2_WDOG_CLK] = wbyte[`SYSOPT_B2_WDOG_CLK]; // [R12]
                                end
                            end
                        end
                        // Identification writes have no effect
                        `SYSOPT_OFF_ID_HIGH, `SYSOPT_OFF_ID_LOW: begin // [R17]
                            st_next.bresp = `SYSOPT_RESP_OKAY;
                        end
                        default: begin
                            st_next.bresp = `SYSOPT_RESP_SLVERR;
                        end
                    endcase
                    st_next.aw_got = 1'b0;
                    st_next.w_got = 1'b0;
                    st_next.wstate = SYSOPT_WRESP;
                end
            end
            SYSOPT_WRESP: begin
                // Response stands until taken
                if (s_axi_bready) begin
                    st_next.wstate = SYSOPT_IDLE;
                end
            end
            default: begin
                st_next.wstate = SYSOPT_IDLE;
            end
        endcase
        // Read channel
        case (st_reg.rstate)
            SYSOPT_IDLE: begin
                if (s_axi_arvalid) begin
                    st_next.rresp = `SYSOPT_RESP_OKAY;
                    st_next.rstate = SYSOPT_RDATA;
                    case (s_axi_araddr)
                        // Readable whether locked or not
                        `SYSOPT_OFF_OPT_ONE: st_next.rdata = {24'h000000, st_reg.opt_one}; // [R02]
                        `SYSOPT_OFF_OPT_TWO: st_next.rdata = {24'h000000, st_reg.opt_two};
                        // Reserved upper nibble reads as zero
                        `SYSOPT_OFF_ID_HIGH: st_next.rdata = {28'h0000000, PART_NUM[11:8]}; // [R16] [R17]
                        `SYSOPT_OFF_ID_LOW: st_next.rdata = {24'h000000, PART_NUM[7:0]}; // [R16]
                        default: begin
                            st_next.rdata = 32'h00000000;
                            st_next.rresp = `SYSOPT_RESP_SLVERR;
                        end
                    endcase
                end
            end
            SYSOPT_RDATA: begin
                if (s_axi_rready) begin
                    st_next.rstate = SYSOPT_IDLE;
                end
            end
            default: begin
                st_next.rstate = SYSOPT_IDLE;
            end
        endcase
        // Non-power resets: locks reopen, debug pin restored, reset pin kept
        if (!other_reset_n) begin
            st_next = st_reg;
            st_next.wstate = SYSOPT_IDLE;
            st_next.rstate = SYSOPT_IDLE;
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.one_locked = 1'b0;
            st_next.two_locked = 1'b0;
            st_next.opt_one = {RST_ONE[7:1], st_reg.opt_one[`SYSOPT_B1_RESET_PIN]}; // [R08] [R10]
            st_next.opt_two = `SYSOPT_RST_OPT_TWO;
        end
    end

    // ----------------------------------------------------------------
    // State register; power-on reset restores everything
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{wstate: SYSOPT_IDLE, rstate: SYSOPT_IDLE, aw_got: 1'b0, w_got: 1'b0,
                        waddr: 4'h0, wdata: 32'h00000000, wstrb: 4'h0, bresp: 2'b00,
                        rdata: 32'h00000000, rresp: 2'b00, one_locked: 1'b0, two_locked: 1'b0,
                        opt_one: `SYSOPT_RST_OPT_ONE, opt_two: `SYSOPT_RST_OPT_TWO}; // [R08] [R10]
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = (st_reg.wstate == SYSOPT_IDLE) && !st_reg.aw_got;
    assign s_axi_wready = (st_reg.wstate == SYSOPT_IDLE) && !st_reg.w_got;
    assign s_axi_bvalid = (st_reg.wstate == SYSOPT_WRESP);
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = (st_reg.rstate == SYSOPT_IDLE);
    assign s_axi_rvalid = (st_reg.rstate == SYSOPT_RDATA);
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    // ----------------------------------------------------------------
    // Option outputs
    // ----------------------------------------------------------------
    assign ctrl.watchdog_enable = st_reg.opt_one[`SYSOPT_B1_WDOG_EN]; // [R04]
    assign ctrl.watchdog_long_timeout = st_reg.opt_one[`SYSOPT_B1_WDOG_LONG]; // [R05]
    assign ctrl.watchdog_clock_select = st_reg.opt_two[`SYSOPT_B2_WDOG_CLK]; // [R12]
    assign ctrl.stop_permit = st_reg.opt_one[`SYSOPT_B1_STOP_PERMIT]; // [R06]
    assign ctrl.debug_pin_enable = st_reg.opt_one[`SYSOPT_B1_DEBUG_PIN]; // [R07]
    assign ctrl.reset_pin_enable = st_reg.opt_one[`SYSOPT_B1_RESET_PIN]; // [R09]
    assign ctrl.reset_pin_pullup = st_reg.opt_one[`SYSOPT_B1_RESET_PIN]; // [R11]
    assign ctrl.serial_periph_pin_select = st_reg.opt_two[`SYSOPT_B2_SPI_SEL]; // [R13]
    assign ctrl.two_wire_pin_select = st_reg.opt_two[`SYSOPT_B2_TWI_SEL]; // [R14]
    assign ctrl.comparator_to_capture = st_reg.opt_two[`SYSOPT_B2_CMP_CAP]; // [R15]
    // Stop with stop not permitted is an illegal opcode
    assign illegal_stop_reset = stop_executed && !st_reg.opt_one[`SYSOPT_B1_STOP_PERMIT]; // [R06]

endmodule : sysopt_regs

//--- sysopt_props.sv
/*
 * Checker of the option register bank, bound to sysopt_regs.
 * Assumes one clock; other_reset_n pulses mask the bus checks.
 */
`timescale 1ns/1ps
module sysopt_props
    import sysopt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic other_reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic stop_executed,
    input wire logic illegal_stop_reset,
    input wire sysopt_ctrl_t ctrl
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    // Soft reset reshapes state, so bus checks pause
    default disable iff (!rst_n || !other_reset_n);
    a_stop_gate: assert property (illegal_stop_reset == (stop_executed && !ctrl.stop_permit))
        else $error("stop reset gate wrong");
    a_pullup_tied: assert property (ctrl.reset_pin_pullup == ctrl.reset_pin_enable)
        else $error("pull-up not tied to pin enable");
    a_debug_back: assert property (disable iff (!rst_n) !other_reset_n |=> ctrl.debug_pin_enable)
        else $error("debug pin not restored");
    a_pin_kept: assert property (disable iff (!rst_n) !other_reset_n |=> $stable(ctrl.reset_pin_enable))
        else $error("reset pin changed by soft reset");
    // A soft reset one edge back is a lawful source of change as well
    a_opts_locked: assert property ($changed(ctrl) && $past(other_reset_n)
        |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("options changed without a write");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer wrong");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
endmodule : sysopt_props

//--- tb.sv
/*
 * Self-checking bench of the option register bank.
 * Assumes package, header and checker compiled before it.
 */
`timescale 1ns/1ps
module tb;
    import sysopt_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, other_reset_n = 1'h1, stop_executed = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic illegal_stop_reset;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    sysopt_ctrl_t ctrl;
    int n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h2c877b8e;
    logic [33:0] rq[$], bq[$]; // Expected answers, oldest first
    sysopt_regs u_dut (.*);
    always #10 clk = ~clk;
    // ----------------------------------------
    // Compare, verdict, monitor
    // ----------------------------------------
    task chk(input logic [33:0] e, input logic [33:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // Answers are taken at the handshake edge
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin // Hang guard
            n_fail++;
            give_verdict();
        end
        if (s_axi_rvalid && s_axi_rready) chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) chk(bq.pop_front(), {s_axi_bresp, 32'h0});
    end
    // ----------------------------------------
    // Bus tasks, entered just after an edge
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        logic aw = 1'h0, w = 1'h0;
        bq.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awready) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        @(posedge clk); // Next call raises bready in a later step
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge clk); // Next call raises rready in a later step
    endtask : rd
    // Expected decoded outputs from both option bytes
    function automatic sysopt_ctrl_t mk(input logic [7:0] a, input logic [7:0] b);
        return {a[7], a[6], b[7], a[5], a[1], a[0], a[0], b[2], b[1], b[0]};
    endfunction : mk
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d, e, k;
        logic [31:0] r;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(4'h0, 32'he3, 2'h0);
        rd(4'h4, 32'h0, 2'h0);
        rd(4'hc, 32'ha1, 2'h0);
        rd(4'h2, 32'h0, 2'h2); // Unmapped place
        chk({24'h0, mk(8'he3, 8'h0)}, {24'h0, ctrl});
        $display("reset values done");
        k = 8'he3;
        for (int i = 0; i < 4; i++) begin
            // Soft reset keeps only the reset pin bit
            other_reset_n <= 1'h0;
            @(posedge clk);
            other_reset_n <= 1'h1;
            @(posedge clk);
            k = {7'h71, k[0]};
            rd(4'h0, {24'h0, k}, 2'h0);
            r = $random(seed);
            d = r[7:0] & 8'he3;
            e = r[15:8] & 8'h87;
            stop_executed <= r[16];
            wr(4'h0, d);
            wr(4'h0, ~d);
            wr(4'h4, e);
            wr(4'h4, ~e & 8'h87);
            wr(4'h8, d);
            wr(4'h2, d, 2'h2); // Unmapped place
            rd(4'h0, {24'h0, d}, 2'h0);
            rd(4'h4, {24'h0, e[7], 4'h0, ~e[2:0]}, 2'h0);
            rd(4'h8, 32'h5, 2'h0);
            chk({24'h0, mk(d, {e[7], 4'h0, ~e[2:0]})}, {24'h0, ctrl});
            chk({33'h0, r[16] & ~d[5]}, {33'h0, illegal_stop_reset});
            k = d;
            $display("option pass %0d done", i);
        end
        // Full reset brings the reset pin back
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rd(4'h0, 32'he3, 2'h0);
        $display("full reset done");
        give_verdict();
    end
endmodule : tb
bind sysopt_regs sysopt_props u_props (.*);
